// File: include/pgh_pkg.sv
// constants for the port g / port h alternate function mux
package pgh_pkg;
  localparam int PGH_G_W = 6;
  localparam int PGH_H_W = 8;
  localparam int PGH_WB_DW = 32;

  // register byte offsets on the wishbone bus
  localparam logic [7:0] PGH_OFS_G_OUT = 8'h00;
  localparam logic [7:0] PGH_OFS_G_DIR = 8'h04;
  localparam logic [7:0] PGH_OFS_G_PIN = 8'h08;
  localparam logic [7:0] PGH_OFS_H_OUT = 8'h0C;
  localparam logic [7:0] PGH_OFS_H_DIR = 8'h10;
  localparam logic [7:0] PGH_OFS_H_PIN = 8'h14;
  localparam logic [7:0] PGH_OFS_CTRL = 8'h18;
  localparam logic [7:0] PGH_OFS_STAT = 8'h1C;

  // control register fields
  localparam int PGH_CTRL_PUD_BIT = 0;

  // status register fields (override owners, read only)
  localparam int PGH_STAT_ASYNC_BIT = 0;
  localparam int PGH_STAT_XMEM_BIT = 1;
  localparam int PGH_STAT_TX_BIT = 2;
  localparam int PGH_STAT_RX_BIT = 3;
  localparam int PGH_STAT_SYNC_BIT = 4;

  // pin positions
  localparam int PGH_G_CMP0B = 5;
  localparam int PGH_G_OSC_IN = 4;
  localparam int PGH_G_OSC_OUT = 3;
  localparam int PGH_G_ALE = 2;
  localparam int PGH_G_RD = 1;
  localparam int PGH_G_WR = 0;
  localparam int PGH_H_T4CLK = 7;
  localparam int PGH_H_XCK = 2;
  localparam int PGH_H_TXD = 1;
  localparam int PGH_H_RXD = 0;

  // reset values
  localparam logic [PGH_G_W-1:0] PGH_G_RST = 6'h00;
  localparam logic [PGH_H_W-1:0] PGH_H_RST = 8'h00;
  localparam logic PGH_PUD_RST = 1'b0;
endpackage

// File: rtl/pgh_mux.sv
// port g / port h alternate function override logic with wishbone port registers
`timescale 1ns/1ns
// Operation
// - pin g5 carries timer0 compare-b output, driven only when its direction bit is set.
// - the same g5 override path also carries the timer0 pwm waveform.
// - async select cuts pin g4 from port logic; it becomes oscillator input.
// - async select cuts pin g3 from port logic; it becomes oscillator output.
// - pin g2 carries address latch enable when external memory owns it.
// - pin g1 carries external memory read strobe when external memory owns it.
// - pin g0 carries external memory write strobe when external memory owns it.
// - pin h7 level is passed to timer4 as its external clock.
// - pin h6 drives timer2 compare-b or pwm only when direction is output.
// - pin h5 drives timer4 compare-c or pwm only when direction is output.
// - pin h4 drives timer4 compare-b or pwm only when direction is output.
// - pin h3 drives timer4 compare-a or pwm only when direction is output.
// - pin h2 is usart2 clock output when direction set, clock input otherwise.
// - the usart2 clock function of h2 acts only in synchronous mode.
// - usart2 receiver enabled forces h0 to input and feeds its level as receive data.
// - while forced to input, a one in h0 output bit turns on pull-up unless the control register pud bit is set.
module pgh_mux #(
  parameter int ADDR_W = 8
) (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic reset_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADDR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [pgh_pkg::PGH_WB_DW-1:0] wb_dat_i,
  output logic [pgh_pkg::PGH_WB_DW-1:0] wb_dat_o,
  output logic wb_ack_o,
  // timer controls and outputs
  input wire logic timer0_compare_b_en_i,
  input wire logic timer0_compare_b_out_i,
  input wire logic timer2_compare_b_en_i,
  input wire logic timer2_compare_b_out_i,
  input wire logic timer4_compare_a_en_i,
  input wire logic timer4_compare_a_out_i,
  input wire logic timer4_compare_b_en_i,
  input wire logic timer4_compare_b_out_i,
  input wire logic timer4_compare_c_en_i,
  input wire logic timer4_compare_c_out_i,
  input wire logic timer2_async_select_i,
  input wire logic external_clock_input_select_i,
  output logic timer4_clock_in_o,
  output logic timer_osc_in_o,
  output logic timer_osc_connect_o,
  // external memory interface
  input wire logic ext_mem_enable_i,
  input wire logic ext_mem_ale_i,
  input wire logic ext_mem_rd_i,
  input wire logic ext_mem_wr_i,
  // usart two
  input wire logic usart_two_sync_mode_i,
  input wire logic usart_two_clock_out_i,
  input wire logic usart_two_tx_enable_i,
  input wire logic usart_two_transmit_data_i,
  input wire logic usart_two_rx_enable_i,
  output logic usart_two_clock_in_o,
  output logic usart_two_receive_data_o,
  // port g pads
  input wire logic [pgh_pkg::PGH_G_W-1:0] pg_pin_i,
  output logic [pgh_pkg::PGH_G_W-1:0] pg_out_o,
  output logic [pgh_pkg::PGH_G_W-1:0] pg_oe_o,
  output logic [pgh_pkg::PGH_G_W-1:0] pg_pu_o,
  output logic [pgh_pkg::PGH_G_W-1:0] pg_in_en_o,
  // port h pads
  input wire logic [pgh_pkg::PGH_H_W-1:0] ph_pin_i,
  output logic [pgh_pkg::PGH_H_W-1:0] ph_out_o,
  output logic [pgh_pkg::PGH_H_W-1:0] ph_oe_o,
  output logic [pgh_pkg::PGH_H_W-1:0] ph_pu_o,
  output logic [pgh_pkg::PGH_H_W-1:0] ph_in_en_o
);
  import pgh_pkg::*;
  if (ADDR_W < 5) begin : g_adr_chk
    $error("pgh_mux: ADDR_W must be at least 5");
  end

  // one override selector shared by every field of every pin
  function automatic logic ovr(input logic en, input logic val, input logic dflt);
    return en ? val : dflt;
  endfunction

  // ---------------- register file ----------------
  logic [PGH_G_W-1:0] g_out_r, g_out_nxt, g_dir_r, g_dir_nxt;
  logic [PGH_H_W-1:0] h_out_r, h_out_nxt, h_dir_r, h_dir_nxt;
  logic pud_r, pud_nxt;
  logic ack_r, ack_nxt;
  logic [PGH_WB_DW-1:0] rdat_r, rdat_nxt;
  logic [PGH_G_W-1:0] g_pin_view;
  logic [PGH_H_W-1:0] h_pin_view;
  logic [7:0] adr8;
  logic req;

  assign adr8 = 8'(wb_adr_i);
  assign req = wb_cyc_i & wb_stb_i;

  always_comb begin
    g_out_nxt = g_out_r;
    g_dir_nxt = g_dir_r;
    h_out_nxt = h_out_r;
    h_dir_nxt = h_dir_r;
    pud_nxt = pud_r;
    rdat_nxt = rdat_r;
    // ack one cycle after the request, dropped the cycle after
    ack_nxt = req & ~ack_r;
    // the write lands at the edge where the master sees ack
    if (req & ack_r & wb_we_i & wb_sel_i[0]) begin
      unique case (adr8)
        PGH_OFS_G_OUT: g_out_nxt = wb_dat_i[PGH_G_W-1:0];
        PGH_OFS_G_DIR: g_dir_nxt = wb_dat_i[PGH_G_W-1:0];
        PGH_OFS_H_OUT: h_out_nxt = wb_dat_i[PGH_H_W-1:0];
        PGH_OFS_H_DIR: h_dir_nxt = wb_dat_i[PGH_H_W-1:0];
        PGH_OFS_CTRL: pud_nxt = wb_dat_i[PGH_CTRL_PUD_BIT];
        default: ;
      endcase
    end
    if (req & ~ack_r) begin
      rdat_nxt = '0;
      unique case (adr8)
        PGH_OFS_G_OUT: rdat_nxt[PGH_G_W-1:0] = g_out_r;
        PGH_OFS_G_DIR: rdat_nxt[PGH_G_W-1:0] = g_dir_r;
        PGH_OFS_G_PIN: rdat_nxt[PGH_G_W-1:0] = g_pin_view;
        PGH_OFS_H_OUT: rdat_nxt[PGH_H_W-1:0] = h_out_r;
        PGH_OFS_H_DIR: rdat_nxt[PGH_H_W-1:0] = h_dir_r;
        PGH_OFS_H_PIN: rdat_nxt[PGH_H_W-1:0] = h_pin_view;
        PGH_OFS_CTRL: rdat_nxt[PGH_CTRL_PUD_BIT] = pud_r;
        PGH_OFS_STAT: begin
          rdat_nxt[PGH_STAT_ASYNC_BIT] = timer2_async_select_i;
          rdat_nxt[PGH_STAT_XMEM_BIT] = ext_mem_enable_i;
          rdat_nxt[PGH_STAT_TX_BIT] = usart_two_tx_enable_i;
          rdat_nxt[PGH_STAT_RX_BIT] = usart_two_rx_enable_i;
          rdat_nxt[PGH_STAT_SYNC_BIT] = usart_two_sync_mode_i;
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      g_out_r <= PGH_G_RST;
      g_dir_r <= PGH_G_RST;
      h_out_r <= PGH_H_RST;
      h_dir_r <= PGH_H_RST;
      pud_r <= PGH_PUD_RST;
      ack_r <= 1'b0;
      rdat_r <= '0;
    end else begin
      g_out_r <= g_out_nxt;
      g_dir_r <= g_dir_nxt;
      h_out_r <= h_out_nxt;
      h_dir_r <= h_dir_nxt;
      pud_r <= pud_nxt;
      ack_r <= ack_nxt;
      rdat_r <= rdat_nxt;
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = rdat_r;

  // ---------------- pin synchronisers ----------------
  logic [PGH_G_W-1:0] g_s1_r, g_s2_r;
  logic [PGH_H_W-1:0] h_s1_r, h_s2_r;

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      g_s1_r <= PGH_G_RST;
      g_s2_r <= PGH_G_RST;
      h_s1_r <= PGH_H_RST;
      h_s2_r <= PGH_H_RST;
    end else begin
      g_s1_r <= pg_pin_i;
      g_s2_r <= g_s1_r;
      h_s1_r <= ph_pin_i;
      h_s2_r <= h_s1_r;
    end
  end

  // ---------------- override tables ----------------
  logic [PGH_G_W-1:0] g_pullup_override_enable, g_pullup_override_value, g_direction_override_enable, g_direction_override_value, g_port_value_override_enable, g_port_value_override_value, g_input_enable_override_enable, g_input_enable_override_value;
  logic [PGH_H_W-1:0] h_pullup_override_enable, h_pullup_override_value, h_direction_override_enable, h_direction_override_value, h_port_value_override_enable, h_port_value_override_value, h_input_enable_override_enable, h_input_enable_override_value;
  logic xck_out_en;

  // the usart clock pin is only claimed in synchronous mode
  assign xck_out_en = usart_two_sync_mode_i & h_dir_r[PGH_H_XCK];

  always_comb begin
    g_pullup_override_enable = '0;
    g_pullup_override_value = '0;
    g_direction_override_enable = '0;
    g_direction_override_value = '0;
    g_port_value_override_enable = '0;
    g_port_value_override_value = '0;
    g_input_enable_override_enable = '0;
    g_input_enable_override_value = '0;
    h_pullup_override_enable = '0;
    h_pullup_override_value = '0;
    h_direction_override_enable = '0;
    h_direction_override_value = '0;
    h_port_value_override_enable = '0;
    h_port_value_override_value = '0;
    h_input_enable_override_enable = '0;
    h_input_enable_override_value = '0;
    // compare and pwm outputs take the value path only; direction stays with software
    g_port_value_override_enable[PGH_G_CMP0B] = timer0_compare_b_en_i;
    g_port_value_override_value[PGH_G_CMP0B] = timer0_compare_b_out_i;
    // oscillator pins: no pull-up, no drive; input buffer on g4 only, and only in external clock mode
    g_pullup_override_enable[PGH_G_OSC_IN] = timer2_async_select_i;
    g_direction_override_enable[PGH_G_OSC_IN] = timer2_async_select_i;
    g_input_enable_override_enable[PGH_G_OSC_IN] = timer2_async_select_i;
    g_input_enable_override_value[PGH_G_OSC_IN] = external_clock_input_select_i;
    g_pullup_override_enable[PGH_G_OSC_OUT] = timer2_async_select_i;
    g_direction_override_enable[PGH_G_OSC_OUT] = timer2_async_select_i;
    g_input_enable_override_enable[PGH_G_OSC_OUT] = timer2_async_select_i;
    // external memory strobes
    g_pullup_override_enable[PGH_G_ALE:PGH_G_WR] = {3{ext_mem_enable_i}};
    g_direction_override_enable[PGH_G_ALE:PGH_G_WR] = {3{ext_mem_enable_i}};
    g_direction_override_value[PGH_G_ALE:PGH_G_WR] = 3'h7;
    g_port_value_override_enable[PGH_G_ALE:PGH_G_WR] = {3{ext_mem_enable_i}};
    g_port_value_override_value[PGH_G_ALE] = ext_mem_ale_i;
    g_port_value_override_value[PGH_G_RD] = ext_mem_rd_i;
    g_port_value_override_value[PGH_G_WR] = ext_mem_wr_i;
    // port h compare outputs
    h_port_value_override_enable[6:3] = {timer2_compare_b_en_i, timer4_compare_c_en_i,
                   timer4_compare_b_en_i, timer4_compare_a_en_i};
    h_port_value_override_value[6:3] = {timer2_compare_b_out_i, timer4_compare_c_out_i,
                   timer4_compare_b_out_i, timer4_compare_a_out_i};
    // usart two
    h_direction_override_enable[PGH_H_XCK] = xck_out_en;
    h_direction_override_value[PGH_H_XCK] = 1'b1;
    h_port_value_override_enable[PGH_H_XCK] = xck_out_en;
    h_port_value_override_value[PGH_H_XCK] = usart_two_clock_out_i;
    h_pullup_override_enable[PGH_H_TXD] = usart_two_tx_enable_i;
    h_direction_override_enable[PGH_H_TXD] = usart_two_tx_enable_i;
    h_direction_override_value[PGH_H_TXD] = 1'b1;
    h_port_value_override_enable[PGH_H_TXD] = usart_two_tx_enable_i;
    h_port_value_override_value[PGH_H_TXD] = usart_two_transmit_data_i;
    h_pullup_override_enable[PGH_H_RXD] = usart_two_rx_enable_i;
    h_pullup_override_value[PGH_H_RXD] = h_out_r[PGH_H_RXD] & ~pud_r;
    h_direction_override_enable[PGH_H_RXD] = usart_two_rx_enable_i;
  end

  // ---------------- final pin resolution ----------------
  logic [PGH_G_W-1:0] g_out_c, g_oe_c, g_pu_c, g_ie_c;
  logic [PGH_H_W-1:0] h_out_c, h_oe_c, h_pu_c, h_ie_c;
  logic t4_clk_nxt, osc_in_nxt, xck_in_nxt, rxd_nxt;
  logic t4_clk_r, osc_in_r, xck_in_r, rxd_r;
  logic [PGH_G_W-1:0] g_out_r2, g_oe_r2, g_pu_r2, g_ie_r2;
  logic [PGH_H_W-1:0] h_out_r2, h_oe_r2, h_pu_r2, h_ie_r2;

  always_comb begin
    for (int i = 0; i < PGH_G_W; i++) begin
      // the plain port pull-up needs input direction and a one in the output bit
      g_pu_c[i] = ovr(g_pullup_override_enable[i], g_pullup_override_value[i], g_out_r[i] & ~g_dir_r[i] & ~pud_r);
      g_oe_c[i] = ovr(g_direction_override_enable[i], g_direction_override_value[i], g_dir_r[i]);
      g_out_c[i] = ovr(g_port_value_override_enable[i], g_port_value_override_value[i], g_out_r[i]);
      g_ie_c[i] = ovr(g_input_enable_override_enable[i], g_input_enable_override_value[i], 1'b1);
    end
    for (int i = 0; i < PGH_H_W; i++) begin
      h_pu_c[i] = ovr(h_pullup_override_enable[i], h_pullup_override_value[i], h_out_r[i] & ~h_dir_r[i] & ~pud_r);
      h_oe_c[i] = ovr(h_direction_override_enable[i], h_direction_override_value[i], h_dir_r[i]);
      h_out_c[i] = ovr(h_port_value_override_enable[i], h_port_value_override_value[i], h_out_r[i]);
      h_ie_c[i] = ovr(h_input_enable_override_enable[i], h_input_enable_override_value[i], 1'b1);
    end
    t4_clk_nxt = h_s2_r[PGH_H_T4CLK] & h_ie_c[PGH_H_T4CLK];
    osc_in_nxt = g_s2_r[PGH_G_OSC_IN] & g_ie_c[PGH_G_OSC_IN];
    // outside synchronous mode the usart sees a quiet low clock
    xck_in_nxt = usart_two_sync_mode_i & ~h_dir_r[PGH_H_XCK] & h_s2_r[PGH_H_XCK];
    // receiver idles high when disabled so no false start bit is seen
    rxd_nxt = usart_two_rx_enable_i ? h_s2_r[PGH_H_RXD] : 1'b1;
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      g_out_r2 <= PGH_G_RST;
      g_oe_r2 <= PGH_G_RST;
      g_pu_r2 <= PGH_G_RST;
      g_ie_r2 <= PGH_G_RST;
      h_out_r2 <= PGH_H_RST;
      h_oe_r2 <= PGH_H_RST;
      h_pu_r2 <= PGH_H_RST;
      h_ie_r2 <= PGH_H_RST;
      t4_clk_r <= 1'b0;
      osc_in_r <= 1'b0;
      xck_in_r <= 1'b0;
      rxd_r <= 1'b1;
    end else begin
      g_out_r2 <= g_out_c;
      g_oe_r2 <= g_oe_c;
      g_pu_r2 <= g_pu_c;
      g_ie_r2 <= g_ie_c;
      h_out_r2 <= h_out_c;
      h_oe_r2 <= h_oe_c;
      h_pu_r2 <= h_pu_c;
      h_ie_r2 <= h_ie_c;
      t4_clk_r <= t4_clk_nxt;
      osc_in_r <= osc_in_nxt;
      xck_in_r <= xck_in_nxt;
      rxd_r <= rxd_nxt;
    end
  end

  assign g_pin_view = g_s2_r & g_ie_c;
  assign h_pin_view = h_s2_r & h_ie_c;
  assign pg_out_o = g_out_r2;
  assign pg_oe_o = g_oe_r2;
  assign pg_pu_o = g_pu_r2;
  assign pg_in_en_o = g_ie_r2;
  assign ph_out_o = h_out_r2;
  assign ph_oe_o = h_oe_r2;
  assign ph_pu_o = h_pu_r2;
  assign ph_in_en_o = h_ie_r2;
  assign timer4_clock_in_o = t4_clk_r;
  assign timer_osc_in_o = osc_in_r;
  assign timer_osc_connect_o = timer2_async_select_i;
  assign usart_two_clock_in_o = xck_in_r;
  assign usart_two_receive_data_o = rxd_r;

  // ---------------- assertions ----------------
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (reset_i);
  sequence s_pin_h7_high;
    ph_pin_i[PGH_H_T4CLK] [*4];
  endsequence
  sequence s_rx_high;
    (usart_two_rx_enable_i && ph_pin_i[PGH_H_RXD]) [*4];
  endsequence

  a_cmp0b_gate: assert property (##1 pg_oe_o[PGH_G_CMP0B] == $past(g_dir_r[PGH_G_CMP0B]) &&
    ($past(timer0_compare_b_en_i) -> pg_out_o[PGH_G_CMP0B] == $past(timer0_compare_b_out_i)))
    else $error("g5 compare output or direction wrong");
  a_osc_cutoff: assert property (timer2_async_select_i |=> !pg_oe_o[PGH_G_OSC_IN] && !pg_pu_o[PGH_G_OSC_IN] &&
    !pg_oe_o[PGH_G_OSC_OUT] && !pg_pu_o[PGH_G_OSC_OUT] && !pg_in_en_o[PGH_G_OSC_OUT])
    else $error("oscillator pins not cut from port");
  a_mem_strobes: assert property (ext_mem_enable_i |=> pg_oe_o[2:0] == 3'h7 && pg_pu_o[2:0] == 3'h0 &&
    pg_out_o[2:0] == {$past(ext_mem_ale_i), $past(ext_mem_rd_i), $past(ext_mem_wr_i)})
    else $error("external memory strobes not on g2..g0");
  a_t4_clock: assert property (s_pin_h7_high |-> timer4_clock_in_o)
    else $error("timer4 clock does not follow h7");
  a_h_cmp_gate: assert property (##1 ph_oe_o[6:3] == $past(h_dir_r[6:3]) &&
    ($past(timer4_compare_a_en_i) -> ph_out_o[3] == $past(timer4_compare_a_out_i)) &&
    ($past(timer2_compare_b_en_i) -> ph_out_o[6] == $past(timer2_compare_b_out_i)))
    else $error("port h compare outputs wrong");
  a_xck_sync: assert property (!usart_two_sync_mode_i |=> !usart_two_clock_in_o &&
    ph_oe_o[PGH_H_XCK] == $past(h_dir_r[PGH_H_XCK]) && ph_out_o[PGH_H_XCK] == $past(h_out_r[PGH_H_XCK]))
    else $error("usart clock pin active outside synchronous mode");
  a_xck_drive: assert property (usart_two_sync_mode_i && h_dir_r[PGH_H_XCK] |=>
    ph_oe_o[PGH_H_XCK] && ph_out_o[PGH_H_XCK] == $past(usart_two_clock_out_i))
    else $error("usart clock not driven out");
  a_rx_input: assert property (usart_two_rx_enable_i |=> !ph_oe_o[PGH_H_RXD] &&
    ph_pu_o[PGH_H_RXD] == ($past(h_out_r[PGH_H_RXD]) && !$past(pud_r)))
    else $error("receive pin not forced to input with pull-up");
  a_rx_data: assert property (s_rx_high |-> usart_two_receive_data_o)
    else $error("receive data does not follow h0");
  a_tx_drive: assert property (usart_two_tx_enable_i |=> ph_oe_o[PGH_H_TXD] && !ph_pu_o[PGH_H_TXD] &&
    ph_out_o[PGH_H_TXD] == $past(usart_two_transmit_data_i))
    else $error("transmit pin not driven");
  a_wb_ack: assert property (req && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
    else $error("wishbone ack timing wrong");
endmodule

// File: dv/pgh_periph_model.sv
// behavioural model of the timers, usart two and external memory controller
`timescale 1ns/1ns
module pgh_periph_model (
  // clock
  input wire logic ref_clk_i,
  // scenario command from the bench
  input wire logic [20:0] cmd_i,
  // peripheral signals toward the mux
  output logic [20:0] per_o
);
  // bit map: 0..9 compare enable/value pairs (t0b,t2b,t4a,t4b,t4c), 10 async, 11 ext clock,
  // 12 ext mem enable, 13 ale, 14 rd, 15 wr, 16 sync, 17 clock out, 18 tx en, 19 tx data, 20 rx en
  logic [20:0] per_r;
  // real peripherals launch from flops, so changes reach the mux one edge late
  always_ff @(posedge ref_clk_i) begin
    per_r <= cmd_i;
  end
  assign per_o = per_r;
endmodule

// File: dv/pgh_mux_bench.sv
// self-checking bench for the port g / port h alternate function mux
`timescale 1ns/1ns
module pgh_mux_bench;
  import pgh_pkg::*;
  logic ref_clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0000_0000;
  logic [20:0] cmd = 21'h00_0000;
  logic [5:0] pg_pin_i = 6'h00;
  logic [7:0] ph_pin_i = 8'h00;
  wire logic [31:0] wb_dat_o;
  wire logic wb_ack_o;
  wire logic [20:0] per;
  wire logic timer4_clock_in_o;
  wire logic timer_osc_in_o;
  wire logic timer_osc_connect_o;
  wire logic usart_two_clock_in_o;
  wire logic usart_two_receive_data_o;
  wire logic [5:0] pg_out_o;
  wire logic [5:0] pg_oe_o;
  wire logic [5:0] pg_pu_o;
  wire logic [5:0] pg_in_en_o;
  wire logic [7:0] ph_out_o;
  wire logic [7:0] ph_oe_o;
  wire logic [7:0] ph_pu_o;
  wire logic [7:0] ph_in_en_o;
  int err_total = 0;
  int check_count = 0;
  logic [31:0] q;

  always #5 ref_clk_i = ~ref_clk_i;

  pgh_periph_model partner (.ref_clk_i, .cmd_i(cmd), .per_o(per));

  pgh_mux #(.ADDR_W(8)) uut (
    .ref_clk_i, .reset_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
    .wb_dat_o, .wb_ack_o,
    .timer0_compare_b_en_i(per[0]), .timer0_compare_b_out_i(per[1]),
    .timer2_compare_b_en_i(per[2]), .timer2_compare_b_out_i(per[3]),
    .timer4_compare_a_en_i(per[4]), .timer4_compare_a_out_i(per[5]),
    .timer4_compare_b_en_i(per[6]), .timer4_compare_b_out_i(per[7]),
    .timer4_compare_c_en_i(per[8]), .timer4_compare_c_out_i(per[9]),
    .timer2_async_select_i(per[10]), .external_clock_input_select_i(per[11]),
    .timer4_clock_in_o, .timer_osc_in_o, .timer_osc_connect_o,
    .ext_mem_enable_i(per[12]), .ext_mem_ale_i(per[13]), .ext_mem_rd_i(per[14]), .ext_mem_wr_i(per[15]),
    .usart_two_sync_mode_i(per[16]), .usart_two_clock_out_i(per[17]), .usart_two_tx_enable_i(per[18]),
    .usart_two_transmit_data_i(per[19]), .usart_two_rx_enable_i(per[20]),
    .usart_two_clock_in_o, .usart_two_receive_data_o,
    .pg_pin_i, .pg_out_o, .pg_oe_o, .pg_pu_o, .pg_in_en_o,
    .ph_pin_i, .ph_out_o, .ph_oe_o, .ph_pu_o, .ph_in_en_o
  );

  task automatic test_done;
    if (err_total == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      err_total++;
    end
  endtask

  // one classic cycle; held until ack is sampled high, then released for at least one cycle
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= 4'hF;
    // no cycle count is assumed while waiting; only the watchdog ends a lost answer
    do begin
      @(posedge ref_clk_i);
      n++;
    end while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    // the slave answers in the cycle after it takes the request
    chk(32'(n), 32'h0000_0002);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0000_0000);
    chk(q, e);
  endtask

  // pads answer one cycle late, pin inputs three; five edges covers both
  task automatic sc(input logic [20:0] v);
    @(posedge ref_clk_i);
    cmd <= v;
    repeat (5) @(posedge ref_clk_i);
  endtask

  initial begin
    repeat (12) @(posedge ref_clk_i);
    reset_i <= 1'b0;
    @(posedge ref_clk_i);
    chk(32'(pg_oe_o), 32'h0);
    chk(32'(ph_oe_o), 32'h0);
    chk(32'(usart_two_receive_data_o), 32'h1);
    // every register reads zero after reset with pins and peripheral inputs low; 0x20 is unmapped and reads zero
    for (int i = 0; i < 9; i++) begin
      rd(8'(i * 4), 32'h0000_0000);
    end
    wb(1'b1, PGH_OFS_G_DIR, 32'h0000_0020);
    wb(1'b1, PGH_OFS_H_DIR, 32'h0000_0078);
    rd(PGH_OFS_H_DIR, 32'h0000_0078);
    for (int v = 0; v < 2; v++) begin
      sc(21'h00_0155 | (v != 0 ? 21'h00_02AA : 21'h00_0000));
      chk(32'(pg_out_o[5]), 32'(v));
      chk(32'(pg_oe_o[5]), 32'h1);
      chk(32'(ph_out_o[6:3]), v != 0 ? 32'hF : 32'h0);
      chk(32'(ph_oe_o[6:3]), 32'hF);
    end
    wb(1'b1, PGH_OFS_G_DIR, 32'h0000_0000);
    wb(1'b1, PGH_OFS_H_DIR, 32'h0000_0000);
    sc(21'h00_03FF);
    chk(32'(pg_oe_o[5]), 32'h0);
    chk(32'(ph_oe_o[6:3]), 32'h0);
    // strobes take the pins even though software left them as inputs with pull-ups on
    wb(1'b1, PGH_OFS_G_OUT, 32'h0000_0007);
    sc(21'h00_0000);
    chk(32'(pg_pu_o[2:0]), 32'h7);
    sc(21'h00_B000);
    chk(32'(pg_oe_o[2:0]), 32'h7);
    chk(32'(pg_pu_o[2:0]), 32'h0);
    chk(32'(pg_out_o[2:0]), 32'h5);
    sc(21'h00_5000);
    chk(32'(pg_out_o[2:0]), 32'h2);
    wb(1'b1, PGH_OFS_G_OUT, 32'h0000_0018);
    wb(1'b1, PGH_OFS_G_DIR, 32'h0000_0018);
    pg_pin_i <= 6'h10;
    sc(21'h00_0C00);
    chk(32'(pg_oe_o[4:3]), 32'h0);
    chk(32'(pg_pu_o[4:3]), 32'h0);
    chk(32'(pg_in_en_o[4:3]), 32'h2);
    chk(32'(timer_osc_connect_o), 32'h1);
    chk(32'(timer_osc_in_o), 32'h1);
    // crystal mode without external clock: both pins lose their input buffers
    sc(21'h00_0400);
    chk(32'(pg_in_en_o[4:3]), 32'h0);
    chk(32'(timer_osc_in_o), 32'h0);
    rd(PGH_OFS_G_PIN, 32'h0000_0000);
    sc(21'h00_0000);
    chk(32'(pg_oe_o[4:3]), 32'h3);
    chk(32'(pg_out_o[4:3]), 32'h3);
    ph_pin_i <= 8'h80;
    sc(21'h00_0000);
    chk(32'(timer4_clock_in_o), 32'h1);
    chk(32'(ph_in_en_o), 32'h0000_00FF);
    rd(PGH_OFS_H_PIN, 32'h0000_0080);
    ph_pin_i <= 8'h00;
    sc(21'h00_0000);
    chk(32'(timer4_clock_in_o), 32'h0);
    wb(1'b1, PGH_OFS_H_DIR, 32'h0000_0004);
    sc(21'h03_0000);
    chk(32'(ph_oe_o[2]), 32'h1);
    chk(32'(ph_out_o[2]), 32'h1);
    sc(21'h02_0000);
    chk(32'(ph_out_o[2]), 32'h0);
    wb(1'b1, PGH_OFS_H_DIR, 32'h0000_0000);
    ph_pin_i <= 8'h04;
    sc(21'h01_0000);
    chk(32'(ph_oe_o[2]), 32'h0);
    chk(32'(usart_two_clock_in_o), 32'h1);
    sc(21'h00_0000);
    chk(32'(usart_two_clock_in_o), 32'h0);
    // transmitter and receiver together, with software direction opposite to what they force
    wb(1'b1, PGH_OFS_H_OUT, 32'h0000_0003);
    wb(1'b1, PGH_OFS_H_DIR, 32'h0000_0001);
    ph_pin_i <= 8'h00;
    sc(21'h1C_0000);
    chk(32'(ph_oe_o[1:0]), 32'h2);
    chk(32'(ph_pu_o[1:0]), 32'h1);
    chk(32'(ph_out_o[1]), 32'h1);
    chk(32'(usart_two_receive_data_o), 32'h0);
    rd(PGH_OFS_STAT, 32'h0000_000C);
    wb(1'b1, PGH_OFS_CTRL, 32'h0000_0001);
    ph_pin_i <= 8'h01;
    sc(21'h14_0000);
    chk(32'(ph_pu_o[0]), 32'h0);
    chk(32'(ph_out_o[1]), 32'h0);
    chk(32'(usart_two_receive_data_o), 32'h1);
    test_done;
  end

  initial begin
    #200000;
    err_total++;
    test_done;
  end
endmodule
